// File: rtl/bus_area_control.v
// Bus area control register with APB access and pin-state control outputs
`timescale 1ns/1ps
`include "bus_area_control_map.vh"

module bus_area_control #(
   parameter ADDR_WIDTH = 12
) (
   // Clock and power-on reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Bus state inputs from the bus state controller
   input wire bus_ack,
   input wire data_bus_busy,
   input wire standby_mode,
   input wire bus_released,
   // Strap pin
   input wire byte_order_mode_pin,
   // Pin control outputs
   output reg addr_pullup_en,
   output reg data_pullup_en,
   output reg standby_mem_pin_oe,
   output reg standby_mem_pin_level,
   output reg strobe_pin_oe,
   // Decoded configuration
   output reg little_endian,
   output reg [4:0] area0_burst_len,
   output reg [4:0] area5_burst_len,
   output reg [4:0] area6_burst_len,
   output reg area2_sdram,
   output reg area3_sdram,
   output reg memtype_prohibited,
   output reg area5_card_space,
   output reg area6_card_space
);

   // Register storage and APB state
   reg [15:0] ctrl_ff;
   reg [15:0] nxt_ctrl;
   reg byte_order_ff;
   reg [31:0] nxt_rdata;
   reg nxt_slverr;
   wire addr_hit;
   wire setup_phase;
   wire write_done;
   wire [15:0] read_value;
   wire [15:0] wr_merged;

   // Strap capture
   reg [2:0] strap_sync_ff;
   reg [1:0] settle_ff;
   reg strap_taken_ff;

   // Address pull-up pulse
   reg bus_ack_d_ff;
   reg [2:0] pullup_cnt_ff;
   reg [2:0] nxt_pullup_cnt;

   // Burst decode
   wire [5:0] burst_codes;
   wire [14:0] burst_lens;

   // Memory type decode
   reg nxt_area2_sdram;
   reg nxt_area3_sdram;
   reg nxt_memtype_bad;

   // Byte address of the register, cut to the bus width on purpose
   localparam [ADDR_WIDTH-1:0] reg_byte_addr = `BAC_OFFSET;

   // Address bits 1:0 select a byte lane and take no part in the decode
   assign addr_hit = (paddr[ADDR_WIDTH-1:2] == reg_byte_addr[ADDR_WIDTH-1:2]);
   assign setup_phase = psel & ~penable;
   // A write lands only at the access edge, with ready high
   assign write_done = psel & penable & pready & pwrite & addr_hit;

   // Bit 11 always reflects the captured strap
   assign read_value = {ctrl_ff[15:12], byte_order_ff, ctrl_ff[10:0]};

   // Byte lanes merged into the writable bits only; lanes 2 and 3 hold no bits here
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : lane_merge
         assign wr_merged[b*8+7:b*8] = pstrb[b] ? pwdata[b*8+7:b*8] : ctrl_ff[b*8+7:b*8];
      end
   endgenerate

   // APB answer one cycle after setup
   // Zero wait states: ready, data and error stand for the access cycle only
   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_slverr = 1'b0;
      if (setup_phase) begin
         if (!addr_hit) begin
            nxt_slverr = 1'b1;
         end else if (!pwrite) begin
            nxt_rdata = {16'h0000, read_value};
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         prdata <= nxt_rdata;
         pslverr <= nxt_slverr;
      end
   end

   // Register write; only power-on reset clears it
   always @* begin
      nxt_ctrl = ctrl_ff;
      if (write_done) begin
         nxt_ctrl = (wr_merged & `BAC_WR_MASK) | (ctrl_ff & ~`BAC_WR_MASK);
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `BAC_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // Strap pin synchroniser; the pin is asynchronous to pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_sync_ff <= 3'h0;
      end else begin
         strap_sync_ff <= {strap_sync_ff[1:0], byte_order_mode_pin};
      end
   end

   // One-time capture once the last two stages agree, so a bouncing strap is not taken
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_ff <= 2'h0;
         strap_taken_ff <= 1'b0;
         byte_order_ff <= 1'b0;
      end else begin
         if (settle_ff != `STRAP_SETTLE_CYCLES) begin
            settle_ff <= settle_ff + 2'h1;
         end
         if (!strap_taken_ff && settle_ff == `STRAP_SETTLE_CYCLES &&
             strap_sync_ff[1] == strap_sync_ff[2]) begin
            byte_order_ff <= strap_sync_ff[2];
            strap_taken_ff <= 1'b1;
         end
      end
   end

   // Address pull-up counter started by the rising edge of bus acknowledge
   always @* begin
      nxt_pullup_cnt = pullup_cnt_ff;
      if (bus_ack && !bus_ack_d_ff && ctrl_ff[`BAC_ADDR_PULLUP]) begin
         nxt_pullup_cnt = `ADDR_PULLUP_CYCLES;
      end else if (pullup_cnt_ff != 3'h0) begin
         nxt_pullup_cnt = pullup_cnt_ff - 3'h1;
      end
   end

   // Delayed bus acknowledge for the rising-edge detect; resets to the idle level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_ack_d_ff <= 1'b0;
      end else begin
         bus_ack_d_ff <= bus_ack;
      end
   end

   // Pulse counter; a running pulse still finishes after bit 15 is cleared
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_cnt_ff <= 3'h0;
         addr_pullup_en <= 1'b0;
      end else begin
         pullup_cnt_ff <= nxt_pullup_cnt;
         addr_pullup_en <= (nxt_pullup_cnt != 3'h0);
      end
   end

   // Burst fields of areas 0, 5 and 6 decoded alike
   assign burst_codes = {ctrl_ff[`BAC_A6_BURST_HI:`BAC_A6_BURST_LO],
                         ctrl_ff[`BAC_A5_BURST_HI:`BAC_A5_BURST_LO],
                         ctrl_ff[`BAC_A0_BURST_HI:`BAC_A0_BURST_LO]};

   // Code 00 gives no burst, codes 01, 10 and 11 give 4, 8 and 16 accesses
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : burst_dec
         assign burst_lens[g*5+4:g*5] =
            (burst_codes[g*2+1:g*2] == `BURST_4) ? `BURST_LEN_4 :
            (burst_codes[g*2+1:g*2] == `BURST_8) ? `BURST_LEN_8 :
            (burst_codes[g*2+1:g*2] == `BURST_16) ? `BURST_LEN_16 :
            `BURST_LEN_NONE;
      end
   endgenerate

   // Memory type decode; a prohibited code leaves both areas ordinary and raises a flag
   always @* begin
      nxt_area2_sdram = 1'b0;
      nxt_area3_sdram = 1'b0;
      nxt_memtype_bad = 1'b0;
      case (ctrl_ff[`BAC_MEMTYPE_HI:`BAC_MEMTYPE_LO])
         `MEMTYPE_ORDINARY: begin
            nxt_area3_sdram = 1'b0;
         end
         `MEMTYPE_A3_SDRAM: begin
            nxt_area3_sdram = 1'b1;
         end
         `MEMTYPE_BOTH_SDRAM: begin
            nxt_area2_sdram = 1'b1;
            nxt_area3_sdram = 1'b1;
         end
         default: begin
            nxt_memtype_bad = 1'b1;
         end
      endcase
   end

   // Pin control outputs; outside standby and bus release the pins belong to the bus cycle logic
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_pullup_en <= 1'b0;
         standby_mem_pin_oe <= 1'b0;
         standby_mem_pin_level <= 1'b0;
         strobe_pin_oe <= 1'b0;
      end else begin
         data_pullup_en <= ctrl_ff[`BAC_DATA_PULLUP] & ~data_bus_busy;
         standby_mem_pin_oe <= standby_mode & ctrl_ff[`BAC_STANDBY_DRIVE];
         standby_mem_pin_level <= standby_mode & ctrl_ff[`BAC_STANDBY_DRIVE];
         strobe_pin_oe <= ~(standby_mode | bus_released) | ctrl_ff[`BAC_STROBE_DRIVE];
      end
   end

   // Decoded configuration, one clock behind the register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         little_endian <= 1'b0;
         area0_burst_len <= `BURST_LEN_NONE;
         area5_burst_len <= `BURST_LEN_NONE;
         area6_burst_len <= `BURST_LEN_NONE;
         area5_card_space <= 1'b0;
         area6_card_space <= 1'b0;
      end else begin
         little_endian <= byte_order_ff;
         area0_burst_len <= burst_lens[4:0];
         area5_burst_len <= burst_lens[9:5];
         area6_burst_len <= burst_lens[14:10];
         area5_card_space <= ctrl_ff[`BAC_A5_CARD];
         area6_card_space <= ctrl_ff[`BAC_A6_CARD];
      end
   end

   // Memory type outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         area2_sdram <= 1'b0;
         area3_sdram <= 1'b0;
         memtype_prohibited <= 1'b0;
      end else begin
         area2_sdram <= nxt_area2_sdram;
         area3_sdram <= nxt_area3_sdram;
         memtype_prohibited <= nxt_memtype_bad;
      end
   end

endmodule

// File: rtl/bus_area_control_map.vh
// Register map and constants of the bus area control register block
`ifndef BUS_AREA_CONTROL_MAP_VH
`define BUS_AREA_CONTROL_MAP_VH

// Register offset (byte address on APB)
`define BAC_OFFSET 12'h000

// Register width and reset value
`define BAC_WIDTH 16
`define BAC_RESET 16'h0000

// Mask of software-writable bits (bit 11 is read-only)
`define BAC_WR_MASK 16'hF7FF

// Field positions
`define BAC_ADDR_PULLUP 15
`define BAC_DATA_PULLUP 14
`define BAC_STANDBY_DRIVE 13
`define BAC_STROBE_DRIVE 12
`define BAC_BYTE_ORDER 11
`define BAC_A0_BURST_HI 10
`define BAC_A0_BURST_LO 9
`define BAC_A5_BURST_HI 8
`define BAC_A5_BURST_LO 7
`define BAC_A6_BURST_HI 6
`define BAC_A6_BURST_LO 5
`define BAC_MEMTYPE_HI 4
`define BAC_MEMTYPE_LO 2
`define BAC_A5_CARD 1
`define BAC_A6_CARD 0

// Memory type codes for areas 2 and 3
`define MEMTYPE_ORDINARY 3'h0
`define MEMTYPE_A3_SDRAM 3'h2
`define MEMTYPE_BOTH_SDRAM 3'h3

// Burst length codes
`define BURST_NONE 2'h0
`define BURST_4 2'h1
`define BURST_8 2'h2
`define BURST_16 2'h3

// Burst lengths in accesses
`define BURST_LEN_NONE 5'h00
`define BURST_LEN_4 5'h04
`define BURST_LEN_8 5'h08
`define BURST_LEN_16 5'h10

// Address pull-up duration after bus acknowledge, in clock cycles
`define ADDR_PULLUP_CYCLES 3'h4

// Cycles after reset release before the byte-order pin is captured
`define STRAP_SETTLE_CYCLES 2'h3

`endif

// File: verif/bus_area_control_properties.sv
// Concurrent checks on the bus area control register ports
`timescale 1ns/1ps
module bus_area_control_properties #(
   parameter ADDR_WIDTH = 12
) (
   // Clock, reset and APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] prdata,
   // Bus state inputs
   input wire bus_ack,
   input wire data_bus_busy,
   input wire standby_mode,
   input wire bus_released,
   // Pin control and decoded outputs
   input wire addr_pullup_en,
   input wire data_pullup_en,
   input wire standby_mem_pin_oe,
   input wire strobe_pin_oe,
   input wire little_endian,
   input wire area2_sdram,
   input wire area3_sdram,
   input wire memtype_prohibited,
   input wire [4:0] area0_burst_len
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_unmapped_error: assert property (psel && !penable && paddr[ADDR_WIDTH-1:2] != 0 |=> pslverr && prdata == 0)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_pullup_four: assert property ($rose(addr_pullup_en) |-> $past(bus_ack) ##0 addr_pullup_en [*4])
      else $error("address pull-up pulse wrong");
   a_data_pullup_idle: assert property (data_pullup_en |-> !$past(data_bus_busy))
      else $error("data pull-up while bus busy");
   a_standby_drive: assert property (standby_mem_pin_oe |-> $past(standby_mode))
      else $error("memory pins driven outside standby");
   a_strobe_float: assert property ($past(presetn) && !strobe_pin_oe |-> $past(standby_mode) || $past(bus_released))
      else $error("strobes floated while bus active");
   a_burst_codes: assert property (area0_burst_len inside {5'h00, 5'h04, 5'h08, 5'h10})
      else $error("illegal burst length");
   a_memtype_legal: assert property (area2_sdram |-> area3_sdram && !memtype_prohibited)
      else $error("illegal memory type decode");
   a_endian_kept: assert property ($past(presetn) && $past(little_endian) |-> little_endian)
      else $error("byte order changed without reset");
   cover property ($rose(addr_pullup_en));
   cover property (pslverr);
   cover property (area2_sdram);
endmodule

bind bus_area_control bus_area_control_properties #(.ADDR_WIDTH(ADDR_WIDTH)) props (.*);

// File: verif/tb_top.sv
// Self-checking bench for the bus area control register
`timescale 1ns/1ps
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_ack = 0, data_bus_busy = 0;
   logic standby_mode = 0, bus_released = 0, byte_order_mode_pin = 1, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic addr_pullup_en, data_pullup_en, standby_mem_pin_oe, standby_mem_pin_level, strobe_pin_oe;
   logic little_endian, area2_sdram, area3_sdram, memtype_prohibited, area5_card_space, area6_card_space;
   logic [4:0] area0_burst_len, area5_burst_len, area6_burst_len;
   int fails = 0, comparisons = 0, n;
   typedef struct {logic [15:0] w, r; logic [19:0] d;} row_t;
   // Rows mix legal software settings with prohibited memory type codes
   row_t rows [5] = '{'{16'hFFFF, 16'hFFFF, 20'h84207}, '{16'h0000, 16'h0800, 20'h00000},
      '{16'h0289, 16'h0A89, 20'h21009}, '{16'h054E, 16'h0D4E, 20'h4211A}, '{16'h0024, 16'h0824, 20'h00084}};

   bus_area_control dut (.*);

   task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      // The answer is taken at the edge where ready is sampled high, then released
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task results;
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial forever #2.5 pclk = ~pclk;

   initial begin
      repeat (5000) @(posedge pclk);
      fails++;
      results;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      repeat (8) @(posedge pclk);
      apb(0, 12'h000, 0, 4'hF);
      chk("reset", {rd, little_endian}, {32'h00000800, 1'b1});
      foreach (rows[i]) begin
         apb(1, 12'h000, {16'h0000, rows[i].w}, 4'hF);
         apb(0, 12'h000, 0, 4'hF);
         chk("readback", rd, {16'h0000, rows[i].r});
         chk("decode", {area0_burst_len, area5_burst_len, area6_burst_len, area2_sdram, area3_sdram,
            memtype_prohibited, area5_card_space, area6_card_space}, rows[i].d);
      end
      apb(1, 12'h000, 32'hFFFFFFFF, 4'h1);
      apb(1, 12'h004, 32'h0000FFFF, 4'hF);
      chk("unmapped_wr", err, 1);
      apb(0, 12'h004, 0, 4'hF);
      chk("unmapped_rd", {err, rd}, {1'b1, 32'h00000000});
      apb(0, 12'h000, 0, 4'hF);
      chk("lanes", rd, 32'h000008FF);
      for (int k = 0; k < 2; k++) begin
         apb(1, 12'h000, k ? 32'h00000000 : 32'h00008000, 4'hF);
         @(posedge pclk) bus_ack <= 1;
         n = 0;
         repeat (8) begin
            @(negedge pclk);
            n += (addr_pullup_en === 1'b1);
         end
         @(posedge pclk) bus_ack <= 0;
         chk("pullup", n, k ? 0 : 4);
      end
      apb(1, 12'h000, 32'h00004000, 4'hF);
      repeat (2) @(negedge pclk);
      chk("data_pu_idle", data_pullup_en, 1);
      @(posedge pclk) data_bus_busy <= 1;
      repeat (2) @(negedge pclk);
      chk("data_pu_busy", data_pullup_en, 0);
      @(posedge pclk) data_bus_busy <= 0;
      for (int k = 0; k < 2; k++) begin
         apb(1, 12'h000, k ? 32'h00003000 : 32'h00000000, 4'hF);
         @(posedge pclk) standby_mode <= 1;
         repeat (2) @(negedge pclk);
         chk("standby", {standby_mem_pin_oe, strobe_pin_oe, standby_mem_pin_level | ~standby_mem_pin_oe},
            {k[0], k[0], 1'b1});
         apb(0, 12'h000, 0, 4'hF);
         chk("kept", rd, k ? 32'h00003800 : 32'h00000800);
         @(posedge pclk);
         standby_mode <= 0;
         bus_released <= 1;
         repeat (2) @(negedge pclk);
         chk("released", {standby_mem_pin_oe, strobe_pin_oe}, {1'b0, k[0]});
         @(posedge pclk) bus_released <= 0;
      end
      @(posedge pclk);
      presetn <= 0;
      byte_order_mode_pin <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (8) @(posedge pclk);
      byte_order_mode_pin <= 1;
      apb(0, 12'h000, 0, 4'hF);
      chk("por_clear", {rd, little_endian}, {32'h00000000, 1'b0});
      apb(1, 12'h000, 32'h0000FFFF, 4'hF);
      apb(0, 12'h000, 0, 4'hF);
      chk("endian_ro", {rd, little_endian}, {32'h0000F7FF, 1'b0});
      results;
   end
endmodule
